/* core/serial_port_pkg.sv */
// Constants, field layouts and state types of the shared serial port.
package serial_port_pkg;
  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_TX_BUF = 8'h9A;
  localparam logic [7:0] ADDR_RX_BUF = 8'h9B;
  localparam logic [7:0] ADDR_MODE = 8'hE8;
  localparam logic [7:0] ADDR_TARGET = 8'hE9;
  localparam logic [7:0] ADDR_STATUS = 8'hEA;
  // Reset values, and the byte a slave sends when the FIFO is empty.
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] TARGET_RESET = 8'h00;
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic [7:0] SLAVE_FILL = 8'hFF;
  // SPI view of the mode register (serial_config_one).
  localparam int C1_RATE_LSB = 0;
  localparam int C1_AUTO_SS = 2;
  localparam int C1_SS_INPUT = 3;
  localparam int C1_MASTER = 4;
  localparam int C1_OVR_EN = 5;
  // SPI view of the target register (serial_config_two).
  localparam int C2_CPOL = 1;
  localparam int C2_CPHA = 2;
  localparam int C2_CONT = 7;
  // Two-wire view of the mode and target registers.
  localparam int TW_ENABLE = 7;
  localparam int TW_DIV_LSB = 5;
  localparam int TW_RCOUNT_LSB = 0;
  localparam int TW_DIR = 0;
  // SPI view of the status register.
  localparam int ST_SPI_RX_IRQ = 6;
  localparam int ST_SPI_OVR = 5;
  localparam int ST_SPI_RX_FULL = 3;
  localparam int ST_SPI_TX_EMPTY = 1;
  localparam int ST_SPI_TX_FULL = 0;
  // Two-wire view of the status register.
  localparam int ST_TW_BUSY = 7;
  localparam int ST_TW_NACK = 6;
  localparam int ST_TW_RX_IRQ = 5;
  localparam int ST_TW_TX_EMPTY = 4;
  localparam int ST_TW_FIFO_LSB = 2;
  localparam int ST_TW_WR_ERR = 0;
  // Transmit FIFO shape.
  localparam int TX_FIFO_WIDTH = 8;
  localparam int TX_FIFO_DEPTH = 32;
  // Clock cycles per SCLK half period at rate 0, and per I2C quarter bit.
  localparam logic [5:0] SPI_HALF_BASE = 6'h02;
  localparam int TW_SCL_DIV = 16;
  localparam logic [5:0] TW_QTR_BASE = 6'(TW_SCL_DIV / 4);
  typedef enum logic [2:0] {
    ST_IDLE, M_SHIFT, M_GAP, SLAVE, TW_START, TW_BYTE, TW_STOP
  } port_state_t;
endpackage

/* core/serial_port.sv */
// Shared SPI / two-wire serial port with its transmit FIFO.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Transmit FIFO. DEPTH must be a power of two so the pointers wrap freely.
module tx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } fifo_state_t;
  fifo_state_t s;
  fifo_state_t n;
  logic push;
  logic take;

  // Handshakes come straight from the occupancy count.
  assign in_ready = s.cnt != (AW + 1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rd];
  assign count = s.cnt;

  // Next state; a flush empties the FIFO and drops a same-cycle push.
  always_comb begin
    n = s;
    push = in_valid && in_ready;
    take = out_valid && out_ready;
    if (push) begin
      n.mem[s.wr] = in_data;
      n.wr = s.wr + 1'b1;
    end
    if (take) begin
      n.rd = s.rd + 1'b1;
    end
    if (push && !take) begin
      n.cnt = s.cnt + 1'b1;
    end else if (!push && take) begin
      n.cnt = s.cnt - 1'b1;
    end
    if (flush) begin
      n.rd = '0;
      n.wr = '0;
      n.cnt = '0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Port top: register file, SPI master and slave, two-wire master.
module serial_port
  import serial_port_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic port_protocol_select,
  output logic tx_ready,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_b_in,
  output logic ss_b_out,
  output logic ss_b_oe
);
  typedef struct packed {
    port_state_t st;
    logic [7:0] cfg_a;
    logic [7:0] cfg_b;
    logic [7:0] rx_buf;
    logic [7:0] shreg;
    logic [7:0] rdata;
    logic rx_full;
    logic rx_irq;
    logic ovr;
    logic tx_empty;
    logic nack;
    logic wr_err;
    logic samp;
    logic sclk_lvl;
    logic sclk_prev;
    logic ss_low;
    logic sda_low;
    logic scl_low;
    logic addr_ph;
    logic last;
    logic [5:0] div;
    logic [3:0] bitc;
    logic [1:0] qtr;
    logic [4:0] rxc;
  } core_state_t;

  core_state_t s;
  core_state_t n;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic pop, flush, rx_push, tx_wr, fifo_valid;
  logic [7:0] fifo_data, rx_byte, status_spi, status_tw;
  logic [5:0] fifo_cnt, spi_lim, tw_lim;
  logic spi_mode, tw_pins, tw_on, master, cpha, auto_ss, cont, ovr_en;
  logic tick, tw_st, tw_start, edge_go, smp_edge, byte_done, din, rx_full_eff;
  logic rd_ph, nack_set;

  // Cycles per tick minus one, from a base count and a 2-bit rate field.
  function automatic logic [5:0] div_limit(input logic [5:0] base,
                                           input logic [1:0] sel);
    div_limit = (base << sel) - 6'h01;
  endfunction

  // Reset is released through two flops; assertion stays asynchronous.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // The transmit buffer is a FIFO; a full FIFO refuses the software write.
  tx_byte_fifo #(.WIDTH(TX_FIFO_WIDTH), .DEPTH(TX_FIFO_DEPTH)) u_tx_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(tx_wr),
    .in_ready(tx_ready),
    .in_data(sfr_wdata),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data),
    .count(fifo_cnt)
  );

  // Mode decode; both protocols share the same two config registers.
  assign spi_mode = !port_protocol_select;
  assign tw_pins = port_protocol_select;
  assign tw_on = tw_pins && s.cfg_a[TW_ENABLE];
  assign master = spi_mode && s.cfg_a[C1_MASTER];
  assign auto_ss = s.cfg_a[C1_AUTO_SS];
  assign cpha = s.cfg_b[C2_CPHA];
  assign cont = s.cfg_b[C2_CONT];
  assign ovr_en = spi_mode && s.cfg_a[C1_OVR_EN];
  assign spi_lim = div_limit(SPI_HALF_BASE, s.cfg_a[C1_RATE_LSB +: 2]);
  assign tw_lim = div_limit(TW_QTR_BASE, s.cfg_a[TW_DIV_LSB +: 2]);
  assign tw_st = s.st inside {TW_START, TW_BYTE, TW_STOP};
  assign tick = s.div == (tw_st ? tw_lim : spi_lim);
  assign tx_wr = sfr_wr && sfr_addr == ADDR_TX_BUF;
  assign tw_start = sfr_wr && sfr_addr == ADDR_TARGET && tw_on &&
                    s.st == ST_IDLE;
  assign rd_ph = !s.addr_ph && s.cfg_b[TW_DIR];
  assign rx_full_eff = s.rx_full && !(sfr_rd && sfr_addr == ADDR_RX_BUF);

  // One bit-edge engine serves master (divider ticks) and slave (pin edges).
  assign edge_go = (s.st == M_SHIFT && tick) ||
                   (s.st == SLAVE && !ss_b_in && sclk_in != s.sclk_prev);
  assign smp_edge = !s.bitc[0] ^ cpha;
  assign byte_done = edge_go && s.bitc == 4'hF;
  assign din = master ? miso_in : mosi_in;

  // Pins: SPI drives push-pull, two-wire only ever pulls low.
  assign sclk_out = tw_pins ? 1'b0 : s.sclk_lvl ^ s.cfg_b[C2_CPOL];
  assign sclk_oe = tw_pins ? s.scl_low : master;
  assign mosi_out = tw_pins ? 1'b0 : s.shreg[7];
  assign mosi_oe = tw_pins ? s.sda_low : master;
  assign miso_out = s.shreg[7];
  assign miso_oe = spi_mode && s.st == SLAVE;
  assign ss_b_out = !s.ss_low;
  assign ss_b_oe = master && auto_ss && !s.cfg_a[C1_SS_INPUT];
  assign sfr_rdata = s.rdata;

  // Status words; the same address shows the view of the active protocol.
  always_comb begin
    status_spi = 8'h00;
    status_spi[ST_SPI_RX_IRQ] = s.rx_irq;
    status_spi[ST_SPI_OVR] = s.ovr;
    status_spi[ST_SPI_RX_FULL] = s.rx_full;
    status_spi[ST_SPI_TX_EMPTY] = s.tx_empty;
    status_spi[ST_SPI_TX_FULL] = !tx_ready;
    status_tw = 8'h00;
    status_tw[ST_TW_BUSY] = tw_st;
    status_tw[ST_TW_NACK] = s.nack;
    status_tw[ST_TW_RX_IRQ] = s.rx_irq;
    status_tw[ST_TW_TX_EMPTY] = s.tx_empty;
    status_tw[ST_TW_FIFO_LSB +: 2] = !tx_ready ? 2'b11 :
                                     (fifo_valid ? 2'b10 : 2'b00);
    status_tw[ST_TW_WR_ERR] = s.wr_err;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic. Sets are applied after clears so an event never loses.
  always_comb begin
    n = s;
    pop = 1'b0;
    flush = 1'b0;
    rx_push = 1'b0;
    nack_set = 1'b0;
    rx_byte = {s.shreg[6:0], cpha ? din : s.samp};
    n.sclk_prev = sclk_in;
    n.div = (s.st == ST_IDLE || s.st == SLAVE || tick) ? 6'h00 :
            s.div + 6'h01;
    if (edge_go) begin
      n.bitc = s.bitc + 4'h1;
      if (s.st == M_SHIFT) begin
        n.sclk_lvl = !s.sclk_lvl;
      end
      if (smp_edge) begin
        n.samp = din;
      end else if (s.bitc != 4'h0) begin
        n.shreg = {s.shreg[6:0], s.samp};
      end
    end
    unique case (s.st)
      ST_IDLE: begin
        if (tw_start) begin
          n.st = TW_START;
          n.addr_ph = 1'b1;
          n.shreg = sfr_wdata;
          n.rxc = s.cfg_a[TW_RCOUNT_LSB +: 5];
          n.qtr = 2'b00;
        end else if (master && fifo_valid) begin
          pop = 1'b1;
          n.shreg = fifo_data;
          n.ss_low = auto_ss;
          n.st = M_SHIFT;
          n.bitc = 4'h0;
          n.sclk_lvl = 1'b0;
        end else if (spi_mode && !master && !ss_b_in) begin
          n.st = SLAVE;
          n.bitc = 4'h0;
          pop = fifo_valid;
          n.shreg = fifo_valid ? fifo_data : SLAVE_FILL;
        end
      end
      M_SHIFT: begin
        if (byte_done) begin
          rx_push = 1'b1;
          if (cont && fifo_valid) begin
            pop = 1'b1;
            n.shreg = fifo_data;
          end else begin
            n.ss_low = 1'b0;
            n.st = cont ? ST_IDLE : M_GAP;
          end
        end
      end
      M_GAP: begin
        if (tick) begin
          n.st = ST_IDLE;
        end
      end
      SLAVE: begin
        if (ss_b_in) begin
          n.st = ST_IDLE;
        end else if (byte_done) begin
          rx_push = 1'b1;
          pop = fifo_valid;
          n.shreg = fifo_valid ? fifo_data : SLAVE_FILL;
        end
      end
      TW_START: begin
        if (tick) begin
          n.qtr = s.qtr + 2'b01;
          if (s.qtr == 2'b00) begin
            n.sda_low = 1'b1;
          end else begin
            n.scl_low = 1'b1;
            n.st = TW_BYTE;
            n.qtr = 2'b00;
            n.bitc = 4'h0;
          end
        end
      end
      TW_BYTE: begin
        if (tick) begin
          n.qtr = s.qtr + 2'b01;
          unique case (s.qtr)
            2'b00: begin
              if (s.bitc != 4'h8) begin
                n.sda_low = !rd_ph && !s.shreg[7];
              end else begin
                n.sda_low = rd_ph && !s.last;
              end
            end
            2'b01: n.scl_low = 1'b0;
            2'b10: n.samp = mosi_in;
            2'b11: begin
              n.scl_low = 1'b1;
              n.bitc = s.bitc + 4'h1;
              if (s.bitc != 4'h8) begin
                n.shreg = {s.shreg[6:0], s.samp};
              end else if (rd_ph) begin
                rx_push = 1'b1;
                rx_byte = s.shreg;
                n.bitc = 4'h0;
                n.rxc = s.rxc - 5'h01;
                n.last = s.rxc == 5'h01;
                n.st = s.last ? TW_STOP : TW_BYTE;
              end else if (s.samp) begin
                nack_set = 1'b1;
                n.st = TW_STOP;
              end else if (s.cfg_b[TW_DIR]) begin
                n.addr_ph = 1'b0;
                n.last = s.rxc == 5'h00;
                n.bitc = 4'h0;
              end else if (fifo_valid) begin
                pop = 1'b1;
                n.shreg = fifo_data;
                n.addr_ph = 1'b0;
                n.bitc = 4'h0;
              end else begin
                n.st = TW_STOP;
              end
            end
          endcase
        end
      end
      TW_STOP: begin
        if (tick) begin
          n.qtr = s.qtr + 2'b01;
          unique case (s.qtr)
            2'b00: n.sda_low = 1'b1;
            2'b01: n.scl_low = 1'b0;
            default: begin
              n.sda_low = 1'b0;
              n.st = ST_IDLE;
            end
          endcase
        end
      end
    endcase
    // Register reads; a receive read empties the buffer.
    if (sfr_rd) begin
      unique case (sfr_addr)
        ADDR_RX_BUF: n.rdata = s.rx_buf;
        ADDR_MODE: n.rdata = s.cfg_a;
        ADDR_TARGET: n.rdata = s.cfg_b;
        ADDR_STATUS: n.rdata = tw_pins ? status_tw : status_spi;
        default: n.rdata = 8'h00;
      endcase
      if (sfr_addr == ADDR_RX_BUF) begin
        n.rx_full = 1'b0;
      end
    end
    // Register writes; status flags clear where a zero is written.
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_MODE: n.cfg_a = sfr_wdata;
        ADDR_TARGET: n.cfg_b = sfr_wdata;
        ADDR_TX_BUF: begin
          n.tx_empty = 1'b0;
          n.wr_err = s.wr_err || !tx_ready;
        end
        ADDR_STATUS: begin
          if (tw_pins) begin
            n.nack = s.nack && sfr_wdata[ST_TW_NACK];
            n.rx_irq = s.rx_irq && sfr_wdata[ST_TW_RX_IRQ];
            n.tx_empty = s.tx_empty && sfr_wdata[ST_TW_TX_EMPTY];
            n.wr_err = s.wr_err && sfr_wdata[ST_TW_WR_ERR];
            flush = sfr_wdata[ST_TW_BUSY];
          end else begin
            n.rx_irq = s.rx_irq && sfr_wdata[ST_SPI_RX_IRQ];
            n.ovr = s.ovr && sfr_wdata[ST_SPI_OVR];
            n.tx_empty = s.tx_empty && sfr_wdata[ST_SPI_TX_EMPTY];
          end
        end
        default: ;
      endcase
    end
    // A missing acknowledge wins over a software clear in the same cycle.
    if (nack_set) begin
      n.nack = 1'b1;
    end
    // Loading the shifter with the last buffered byte raises the flag.
    if (pop && fifo_cnt == 6'h01) begin
      n.tx_empty = 1'b1;
    end
    // Receive buffer; an unread byte is kept unless overwrite is enabled.
    if (rx_push) begin
      if (rx_full_eff) begin
        n.ovr = 1'b1;
        if (ovr_en) begin
          n.rx_buf = rx_byte;
          n.rx_irq = 1'b1;
        end
      end else begin
        n.rx_buf = rx_byte;
        n.rx_full = 1'b1;
        n.rx_irq = 1'b1;
      end
    end
  end

  // State register; reset values are all zero, select idles high.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence single_byte_end;
    s.st == M_SHIFT && byte_done && !cont;
  endsequence
  sequence tw_ack_slot;
    s.st == TW_BYTE && tick && s.qtr == 2'b11 && s.bitc == 4'h8;
  endsequence

  slave_release_a: assert property (
    s.st == SLAVE && ss_b_in |=> s.st == ST_IDLE)
    else $error("slave did not end on select release");
  select_held_a: assert property (
    s.st == M_SHIFT && auto_ss |-> !ss_b_out)
    else $error("select high during master byte");
  cont_stop_a: assert property (
    s.st == M_SHIFT && byte_done && cont && !fifo_valid
    |=> s.st == ST_IDLE && ss_b_out)
    else $error("continuous transfer did not stop on empty buffer");
  single_gap_a: assert property (
    single_byte_end |=> s.st == M_GAP && ss_b_out ##1 s.st == M_GAP)
    else $error("no idle gap after single byte");
  tx_clear_a: assert property (
    tx_wr && !(pop && fifo_cnt == 6'h01) |=> !s.tx_empty)
    else $error("transmit write did not clear flag");
  load_flag_a: assert property (
    pop && fifo_cnt == 6'h01 |=> s.tx_empty)
    else $error("flag not raised on shifter load");
  msb_first_a: assert property (
    s.st == ST_IDLE && master && pop
    |=> s.shreg == $past(fifo_data) && mosi_out == s.shreg[7])
    else $error("master byte not loaded msb first");
  rx_new_a: assert property (
    rx_push && !rx_full_eff |=> s.rx_irq && s.rx_full &&
    s.rx_buf == $past(rx_byte))
    else $error("received byte not stored with flag");
  overrun_a: assert property (
    rx_push && rx_full_eff && !ovr_en |=> s.ovr && $stable(s.rx_buf))
    else $error("overrun not flagged or byte not dropped");
  open_drain_a: assert property (
    tw_pins |-> !mosi_out && !sclk_out)
    else $error("two-wire line driven high");
  nack_stop_a: assert property (
    tw_ack_slot and (!rd_ph && s.samp) |=> s.nack && s.st == TW_STOP)
    else $error("missing ack did not stop transfer");
  tw_go_a: assert property (
    tw_start |=> s.st == TW_START ##[1:32] s.sda_low && !s.scl_low)
    else $error("target write did not start transfer");
endmodule

/* testbench/spi_far_slave.sv */
// Far-side SPI slave model: clock mode 0, replies with a counting byte.
`timescale 1ns/10ps
module spi_far_slave (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ss_b,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got,
  output int nbytes
);
  logic [7:0] sh;
  int nb;
  // Start quiet; no frame has been seen yet.
  initial begin
    miso = 1'b1;
    got = 8'h00;
    nbytes = 0;
  end
  // A falling select starts a frame and presents the first reply.
  always @(negedge ss_b) begin
    sh = reply + 8'(nbytes);
    nb = 0;
    miso = sh[7];
  end
  // A released line shows the inverse, so a stale value cannot pass.
  always @(posedge ss_b) miso = !miso;
  // Data is sampled on rising SCLK, most significant bit first.
  always @(posedge sclk) if (!ss_b) begin
    got = {got[6:0], mosi};
    nb++;
    if (nb == 8) nbytes++;
  end
  // The next bit, or the next byte of a long frame, leaves on falling SCLK.
  always @(negedge sclk) if (!ss_b) begin
    sh = (nb == 8) ? reply + 8'(nbytes) : {sh[6:0], 1'b0};
    nb = nb % 8;
    miso = sh[7];
  end
endmodule

/* testbench/test_spi_i2c_shared_serial_port.sv */
// Self-checking bench for the shared serial port.
`timescale 1ns/10ps
module test_spi_i2c_shared_serial_port;
  import serial_port_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic psel = 1'b0;
  logic sclk_drv = 1'b0;
  logic ss_b_drv = 1'b1;
  logic mosi_drv = 1'b0;
  logic [7:0] sfr_rdata, reply, got, q, d1, d2, sv;
  logic tx_ready, sclk_out, sclk_oe, mosi_out, mosi_oe, miso;
  logic miso_out, miso_oe, ss_b_out, ss_b_oe;
  logic [7:0] ra [6] = '{ADDR_RX_BUF, ADDR_MODE, ADDR_TARGET, ADDR_STATUS,
                         ADDR_TX_BUF, 8'h00};
  wire logic scl, sda, ss_line;
  int nbytes, n, div;
  int errors = 0;
  int tests_run = 0;
  int rises = 0;
  time t0, t1;
  serial_port u_serial_port (.ref_clk(ref_clk), .rst_b(rst_b),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .port_protocol_select(psel),
    .tx_ready(tx_ready), .sclk_in(scl), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .mosi_in(sda), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso), .miso_out(miso_out),
    .miso_oe(miso_oe), .ss_b_in(ss_b_drv), .ss_b_out(ss_b_out),
    .ss_b_oe(ss_b_oe));
  spi_far_slave u_spi_far_slave (.sclk(scl), .mosi(sda), .ss_b(ss_line),
    .reply(reply), .miso(miso), .got(got), .nbytes(nbytes));
////////////////////////////////////////////////////////////////////////
  always #50 ref_clk = ~ref_clk;
  // Released lines float high through the pull-ups.
  // While the port is an SPI slave the bench drives SCLK and MOSI.
  assign scl = psel ? !sclk_oe : (sclk_oe ? sclk_out : sclk_drv);
  assign sda = psel ? !mosi_oe : (mosi_oe ? mosi_out : mosi_drv);
  assign ss_line = ss_b_oe ? ss_b_out : 1'b1;
  // Each select release closes one master frame.
  always @(posedge ss_b_out) rises++;
  // Stamp the two latest SCL rises in two-wire mode.
  always @(posedge scl) if (psel) begin
    t0 = t1;
    t1 = $time;
  end
  // Compare and count.
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One register cycle; read data is taken one cycle after the strobe.
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    sfr_wr = w;
    sfr_rd = !w;
    sfr_addr = a;
    sfr_wdata = d;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    q = sfr_rdata;
    @(negedge ref_clk);
  endtask
  // Bounded wait for a frame count, then let the gap state pass.
  task automatic wait_rises(int target);
    for (int i = 0; i < 3000 && rises < target; i++) @(negedge ref_clk);
    repeat (4) @(negedge ref_clk);
    chk("frames", 8'(rises), 8'(target));
  endtask
  // Verdict and end of run.
  task automatic final_report();
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well beyond the longest expected run.
  initial begin
    #8000000;
    errors++;
    final_report();
  end
  // Main sequence.
  initial begin
    void'($urandom(9971));
    reply = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    div = $urandom_range(3, 0);
    repeat (12) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    rises = 0;
    // Reset values; the write-only and unmapped places read zero.
    foreach (ra[i]) begin
      acc(1'b0, ra[i], 8'h00);
      chk("reset", q, 8'h00);
    end
    // Single byte with automatic select.
    acc(1'b1, ADDR_MODE, 8'h14);
    acc(1'b1, ADDR_TX_BUF, d1);
    wait_rises(1);
    chk("mosi", got, d1);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk("status", q, 8'h4A);
    acc(1'b0, ADDR_RX_BUF, 8'h00);
    chk("rx", q, reply);
    // Load with the master off, fill until refused, then flush.
    acc(1'b1, ADDR_MODE, 8'h00);
    acc(1'b1, ADDR_TX_BUF, d1);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk("txe clear", q & 8'h02, 8'h00);
    for (n = 1; n < TX_FIFO_DEPTH; n++) acc(1'b1, ADDR_TX_BUF, d1);
    chk("fifo full", 8'(tx_ready), 8'h00);
    acc(1'b1, ADDR_TX_BUF, d2);
    // Flush and write error live only in the two-wire view of status.
    psel = 1'b1;
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk("refused", q & 8'h1D, 8'h0D);
    acc(1'b1, ADDR_STATUS, 8'h80);
    psel = 1'b0;
    chk("flushed", 8'(tx_ready), 8'h01);
    // Two separate frames; the second byte finds the first unread.
    acc(1'b1, ADDR_TX_BUF, d1);
    acc(1'b1, ADDR_TX_BUF, d2);
    acc(1'b1, ADDR_MODE, 8'h14);
    wait_rises(3);
    chk("mosi", got, d2);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk("overrun", q & 8'h20, 8'h20);
    acc(1'b0, ADDR_RX_BUF, 8'h00);
    chk("rx kept", q, reply + 8'h01);
    // Continuous frame of two bytes with overwrite on overrun.
    acc(1'b1, ADDR_MODE, 8'h00);
    acc(1'b1, ADDR_TARGET, 8'h80);
    acc(1'b1, ADDR_TX_BUF, d2);
    acc(1'b1, ADDR_TX_BUF, d1);
    acc(1'b1, ADDR_MODE, 8'h34);
    wait_rises(4);
    chk("bytes", 8'(nbytes), 8'h05);
    acc(1'b0, ADDR_RX_BUF, 8'h00);
    chk("rx overwrite", q, reply + 8'h04);
    // Two-wire write to an absent slave: no acknowledge arrives.
    psel = 1'b1;
    acc(1'b1, ADDR_MODE, 8'(8'h80 | (div << 5)));
    acc(1'b1, ADDR_TARGET, 8'hA4);
    repeat ((16 << div) * 5) @(negedge ref_clk);
    chk("scl period", 8'((t1 - t0) / 100), 8'(16 << div));
    chk("open drain", {7'h00, sclk_out | mosi_out}, 8'h00);
    q = 8'h00;
    for (n = 0; n < 1000 && q[ST_TW_NACK] !== 1'b1; n++)
      acc(1'b0, ADDR_STATUS, 8'h00);
    chk("no ack", q & 8'h40, 8'h40);
    repeat (16 << div) @(negedge ref_clk);
    acc(1'b1, ADDR_STATUS, 8'h00);
    acc(1'b0, ADDR_STATUS, 8'h00);
    chk("no ack clear", q & 8'h40, 8'h00);
    // SPI slave in clock mode 0; the bench plays the far master.
    psel = 1'b0;
    acc(1'b1, ADDR_MODE, 8'h00);
    acc(1'b1, ADDR_TARGET, 8'h00);
    acc(1'b1, ADDR_TX_BUF, d2);
    ss_b_drv = 1'b0;
    for (n = 7; n >= 0; n--) begin
      mosi_drv = d1[n];
      repeat (2) @(negedge ref_clk);
      sv = {sv[6:0], miso_out};
      sclk_drv = 1'b1;
      repeat (2) @(negedge ref_clk);
      sclk_drv = 1'b0;
    end
    repeat (2) @(negedge ref_clk);
    chk("slave oe", {7'h00, miso_oe}, 8'h01);
    ss_b_drv = 1'b1;
    chk("slave tx", sv, d2);
    acc(1'b0, ADDR_RX_BUF, 8'h00);
    chk("slave rx", q, d1);
    final_report();
  end
endmodule
